// ==== c3io_pkg.sv ====
/*
  Constants shared by the channel 3 timer I/O function selection block.
  Assumes a single system clock and a synchronous active-high reset.
*/
package c3io_pkg;

  localparam int unsigned C3IO_NUM_GR     = 4;
  localparam int unsigned C3IO_CNT_W      = 16;
  localparam int unsigned C3IO_ADDR_W     = 4;
  localparam int unsigned C3IO_DATA_W     = 8;
  localparam int unsigned C3IO_FIELD_W    = 4;

  // Register indices on the register port.
  localparam logic [3:0]  C3IO_IDX_CTRL_HIGH = 4'h0;
  localparam logic [3:0]  C3IO_IDX_CTRL_LOW  = 4'h1;

  // Reset values.
  localparam logic [7:0]  C3IO_CTRL_RST   = 8'h00;
  localparam logic [7:0]  C3IO_RDATA_RST  = 8'h00;
  localparam logic [15:0] C3IO_CNT_RST    = 16'h0000;

  // Field positions within each control register.
  localparam int unsigned C3IO_UPPER_LSB  = 4;
  localparam int unsigned C3IO_LOWER_LSB  = 0;

  // Bit positions within a 4-bit function field.
  localparam int unsigned C3IO_ROLE_BIT   = 3;
  localparam int unsigned C3IO_LEVEL_BIT  = 2;

  // Low two-bit action codes of a function field.
  localparam logic [1:0]  C3IO_ACT_NONE   = 2'h0;
  localparam logic [1:0]  C3IO_ACT_LOW    = 2'h1;
  localparam logic [1:0]  C3IO_ACT_HIGH   = 2'h2;
  localparam logic [1:0]  C3IO_ACT_TOGGLE = 2'h3;

  // Indices of the four general registers.
  localparam int unsigned C3IO_GR_A       = 0;
  localparam int unsigned C3IO_GR_B       = 1;
  localparam int unsigned C3IO_GR_C       = 2;
  localparam int unsigned C3IO_GR_D       = 3;

endpackage

// ==== c3io_sync.sv ====
/*
  Two-stage synchroniser for the channel 3 timer pin inputs.
  Assumes the pins are asynchronous to sys_clk.
*/
`timescale 1ns/10ps
module c3io_sync
  import c3io_pkg::*;
(
  input  wire logic                   sys_clk,  // System clock.
  input  wire logic                   rst,      // Synchronous reset, active high.
  input  wire logic [C3IO_NUM_GR-1:0] async_in, // Raw pin levels.
  output logic      [C3IO_NUM_GR-1:0] sync_out  // Synchronised pin levels.
);

  logic [C3IO_NUM_GR-1:0] meta_q;
  logic [C3IO_NUM_GR-1:0] sync_q;

  genvar gi;
  generate
    for (gi = 0; gi < C3IO_NUM_GR; gi++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule

// ==== c3io_pin_ctrl.sv ====
/*
  Per-register pin logic: output compare drive and input capture edge detection.
  Assumes the match pulse and the pin level are already in the sys_clk domain.
*/
`timescale 1ns/10ps
module c3io_pin_ctrl
  import c3io_pkg::*;
(
  input  wire logic                    sys_clk,   // System clock.
  input  wire logic                    rst,       // Synchronous reset, active high.
  input  wire logic [C3IO_FIELD_W-1:0] field,     // Function field of this register.
  input  wire logic                    load,      // Field written the cycle before.
  input  wire logic                    suppress,  // Register used as a buffer.
  input  wire logic                    match,     // Counter match pulse.
  input  wire logic                    pin_level, // Synchronised pin level.
  output logic                         pin_out,   // Pin output level.
  output logic                         pin_oe,    // Pin output enable.
  output logic                         cap_pulse  // Capture event, one cycle.
);

  logic       level_q;
  logic       level_d;
  logic       oe_q;
  logic       cap_q;
  logic       prev_q;

  wire        is_capture = field[C3IO_ROLE_BIT];
  wire [1:0]  act        = field[1:0];
  wire        active     = !suppress;
  wire        rise       = pin_level && !prev_q;
  wire        fall       = !pin_level && prev_q;
  // Codes 1x capture on both edges; the level bit does not change the source.
  wire        edge_hit   = (act == C3IO_ACT_NONE) ? rise :
                           (act == C3IO_ACT_LOW)  ? fall :
                           (rise || fall);
  wire        cap_d      = active && is_capture && edge_hit;
  wire        oe_d       = active && !is_capture && (act != C3IO_ACT_NONE);
  wire        cmp_hit    = active && !is_capture && match;

  always_comb begin
    level_d = level_q;
    if (load && !is_capture) begin
      level_d = field[C3IO_LEVEL_BIT];
    end else if (cmp_hit) begin
      case (act)
        C3IO_ACT_LOW:    level_d = 1'b0;
        C3IO_ACT_HIGH:   level_d = 1'b1;
        C3IO_ACT_TOGGLE: level_d = !level_q;
        default:         level_d = level_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_q <= 1'b0;
      oe_q    <= 1'b0;
      cap_q   <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      level_q <= level_d;
      oe_q    <= oe_d;
      cap_q   <= cap_d;
      prev_q  <= pin_level;
    end
  end

  assign pin_out   = level_q;
  assign pin_oe    = oe_q;
  assign cap_pulse = cap_q;

endmodule

// ==== c3io_top.sv ====
/*
  Channel 3 timer I/O function selection: two control registers, per-register
  output compare pin drive and input capture of the counter.
  Assumes counter, match pulses and buffer mode bits come from sys_clk logic,
  and the timer pins are asynchronous.
*/
`timescale 1ns/10ps
module c3io_top
  import c3io_pkg::*;
(
  input  wire logic                   sys_clk,        // System clock, 10 MHz.
  input  wire logic                   rst,            // Synchronous reset, active high.
  input  wire logic [C3IO_ADDR_W-1:0] reg_addr,       // Register index.
  input  wire logic [C3IO_DATA_W-1:0] reg_wdata,      // Write data.
  input  wire logic                   reg_wr,         // Write strobe.
  input  wire logic                   reg_rd,         // Read strobe.
  output logic      [C3IO_DATA_W-1:0] reg_rdata,      // Read data, cycle after strobe.
  input  wire logic [C3IO_CNT_W-1:0]  counter,        // Timer counter value.
  input  wire logic [C3IO_NUM_GR-1:0] cmp_match,      // Match pulses, index A..D.
  input  wire logic                   buffer_mode_a,  // C buffers A.
  input  wire logic                   buffer_mode_b,  // D buffers B.
  input  wire logic                   chan3_pin_a_in, // Pin A level.
  input  wire logic                   chan3_pin_b_in, // Pin B level.
  input  wire logic                   chan3_pin_c_in, // Pin C level.
  input  wire logic                   chan3_pin_d_in, // Pin D level.
  output logic      [C3IO_NUM_GR-1:0] pin_out,        // Pin output levels A..D.
  output logic      [C3IO_NUM_GR-1:0] pin_oe,         // Pin output enables A..D.
  output logic      [C3IO_NUM_GR-1:0] cap_strobe,     // Capture pulses A..D.
  output logic      [C3IO_CNT_W-1:0]  chan3_general_a, // Captured value A.
  output logic      [C3IO_CNT_W-1:0]  chan3_general_b, // Captured value B.
  output logic      [C3IO_CNT_W-1:0]  chan3_general_c, // Captured value C.
  output logic      [C3IO_CNT_W-1:0]  chan3_general_d  // Captured value D.
);

  logic [C3IO_DATA_W-1:0]  ctrl_high_q;
  logic [C3IO_DATA_W-1:0]  ctrl_low_q;
  logic [C3IO_DATA_W-1:0]  rdata_q;
  logic [C3IO_CNT_W-1:0]   cap_val_q [C3IO_NUM_GR];
  logic [C3IO_NUM_GR-1:0]  pin_sync;
  logic [C3IO_NUM_GR-1:0]  cap_pulse;
  logic [C3IO_FIELD_W-1:0] field [C3IO_NUM_GR];
  logic [C3IO_NUM_GR-1:0]  load;
  logic [C3IO_NUM_GR-1:0]  suppress;

  // Register decode.
  wire hit_high = (reg_addr == C3IO_IDX_CTRL_HIGH);
  wire hit_low  = (reg_addr == C3IO_IDX_CTRL_LOW);
  wire wr_high  = reg_wr && hit_high;
  wire wr_low   = reg_wr && hit_low;
  wire [C3IO_DATA_W-1:0] rd_sel = hit_high ? ctrl_high_q :
                                  hit_low  ? ctrl_low_q  : C3IO_RDATA_RST;

  // Field extraction.
  assign field[C3IO_GR_A] = ctrl_high_q[C3IO_LOWER_LSB +: C3IO_FIELD_W];
  assign field[C3IO_GR_B] = ctrl_high_q[C3IO_UPPER_LSB +: C3IO_FIELD_W];
  assign field[C3IO_GR_C] = ctrl_low_q[C3IO_LOWER_LSB +: C3IO_FIELD_W];
  assign field[C3IO_GR_D] = ctrl_low_q[C3IO_UPPER_LSB +: C3IO_FIELD_W];

  // Load pulses follow the write by one cycle so the new field is already stored.
  logic wr_high_q;
  logic wr_low_q;
  assign load = {wr_low_q, wr_low_q, wr_high_q, wr_high_q};

  assign suppress[C3IO_GR_A] = 1'b0;
  assign suppress[C3IO_GR_B] = 1'b0;
  assign suppress[C3IO_GR_C] = buffer_mode_a;
  assign suppress[C3IO_GR_D] = buffer_mode_b;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_high_q <= C3IO_CTRL_RST;
      ctrl_low_q  <= C3IO_CTRL_RST;
      wr_high_q   <= 1'b0;
      wr_low_q    <= 1'b0;
    end else begin
      if (wr_high) begin
        ctrl_high_q <= reg_wdata;
      end
      if (wr_low) begin
        ctrl_low_q <= reg_wdata;
      end
      wr_high_q <= wr_high;
      wr_low_q  <= wr_low;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= C3IO_RDATA_RST;
    end else if (reg_rd) begin
      rdata_q <= rd_sel;
    end else begin
      rdata_q <= C3IO_RDATA_RST;
    end
  end

  c3io_sync u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({chan3_pin_d_in, chan3_pin_c_in, chan3_pin_b_in, chan3_pin_a_in}),
    .sync_out (pin_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < C3IO_NUM_GR; gi++) begin : g_gr
      // The role bit of each field picks compare or capture inside the pin logic.
      c3io_pin_ctrl u_pin (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .field     (field[gi]),
        .load      (load[gi]),
        .suppress  (suppress[gi]),
        .match     (cmp_match[gi]),
        .pin_level (pin_sync[gi]),
        .pin_out   (pin_out[gi]),
        .pin_oe    (pin_oe[gi]),
        .cap_pulse (cap_pulse[gi])
      );

      // The counter is sampled in the cycle the capture pulse is raised.
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cap_val_q[gi] <= C3IO_CNT_RST;
        end else if (field[gi][C3IO_ROLE_BIT] && !suppress[gi] && cap_pulse[gi]) begin
          cap_val_q[gi] <= counter;
        end
      end
    end
  endgenerate

  assign reg_rdata       = rdata_q;
  assign cap_strobe      = cap_pulse;
  assign chan3_general_a = cap_val_q[C3IO_GR_A];
  assign chan3_general_b = cap_val_q[C3IO_GR_B];
  assign chan3_general_c = cap_val_q[C3IO_GR_C];
  assign chan3_general_d = cap_val_q[C3IO_GR_D];

endmodule

// ==== c3io_top_asserts.sv ====
/*
  Port assertions for the channel 3 timer I/O block.
  Assumes one clock, a synchronous reset and a bind from the bench top.
*/
`timescale 1ns/10ps
module c3io_top_asserts
  import c3io_pkg::*;
(
  input wire logic                   sys_clk,        // Clock.
  input wire logic                   rst,            // Reset.
  input wire logic [C3IO_ADDR_W-1:0] reg_addr,       // Index.
  input wire logic [C3IO_DATA_W-1:0] reg_wdata,      // Write data.
  input wire logic                   reg_wr,         // Write.
  input wire logic                   reg_rd,         // Read.
  input wire logic [C3IO_DATA_W-1:0] reg_rdata,      // Read data.
  input wire logic [C3IO_CNT_W-1:0]  counter,        // Count.
  input wire logic [C3IO_NUM_GR-1:0] cmp_match,      // Matches.
  input wire logic                   buffer_mode_a,  // C inert.
  input wire logic                   buffer_mode_b,  // D inert.
  input wire logic                   chan3_pin_b_in, // Pin B.
  input wire logic [C3IO_NUM_GR-1:0] pin_out,        // Levels.
  input wire logic [C3IO_NUM_GR-1:0] pin_oe,         // Enables.
  input wire logic [C3IO_NUM_GR-1:0] cap_strobe,     // Captures.
  input wire logic [C3IO_CNT_W-1:0]  chan3_general_a // Value A.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside a read");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > 4'h1 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_AFTER_WR: assert property (reg_wr && reg_addr < 4'h2 ##1
    reg_rd && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback");
  AST_SUPPRESS_C: assert property ($past(buffer_mode_a, 2) && $past(buffer_mode_a)
    |-> !pin_oe[2] && !cap_strobe[2]) else $error("register C active while buffering");
  AST_SUPPRESS_D: assert property ($past(buffer_mode_b, 2) && $past(buffer_mode_b)
    |-> !pin_oe[3] && !cap_strobe[3]) else $error("register D active while buffering");
  AST_CAP_VALUE: assert property (cap_strobe[0] |=> chan3_general_a == $past(counter))
    else $error("captured value wrong");
  AST_CAP_CAUSE: assert property (cap_strobe[1] |->
    $past(chan3_pin_b_in, 3) != $past(chan3_pin_b_in, 4)) else $error("capture without edge");
  AST_PIN_CAUSE: assert property ($changed(pin_out[0]) |-> $past(cmp_match[0]) ||
    $past(cmp_match[0], 2) || $past(reg_wr, 2) || $past(reg_wr, 3)) else $error("pin moved");
endmodule

// ==== c3io_pin_model.sv ====
/*
  Outside circuit on the four channel 3 timer pins.
  Assumes the block drives pin_out and pin_oe from sys_clk.
*/
`timescale 1ns/10ps
module c3io_pin_model (
  input  wire logic [3:0] ext_level, // Level applied from outside.
  input  wire logic [3:0] pin_out,   // Block drive level.
  input  wire logic [3:0] pin_oe,    // Block drive enable.
  output logic      [3:0] pin_in     // Level seen on the pin.
);
  // A driven pin reads back the block's level, a released one the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ==== chan3_io_function_select_test.sv ====
/*
  Self-checking bench for the channel 3 timer I/O block.
  Assumes the package, block, pin model and checker are compiled first.
*/
`timescale 1ns/10ps
module chan3_io_function_select_test;
  import c3io_pkg::*;
  logic        sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0, cmp_match = 4'h0, ext_level = 4'h0, pin_in;
  logic [3:0]  pin_out, pin_oe, cap_strobe;
  logic [1:0]  bmode = 2'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic [15:0] counter = 16'h0000;
  logic [15:0] gr [4];
  logic [15:0] exp_gr [4] = '{default: 16'h0000};
  int          miscompares = 0, num_checks = 0, cycles = 0;

  c3io_top dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .counter, .cmp_match, .buffer_mode_a(bmode[0]), .buffer_mode_b(bmode[1]),
    .chan3_pin_a_in(pin_in[0]), .chan3_pin_b_in(pin_in[1]), .chan3_pin_c_in(pin_in[2]),
    .chan3_pin_d_in(pin_in[3]), .pin_out, .pin_oe, .cap_strobe, .chan3_general_a(gr[0]),
    .chan3_general_b(gr[1]), .chan3_general_c(gr[2]), .chan3_general_d(gr[3]));
  c3io_pin_model pins (.ext_level, .pin_out, .pin_oe, .pin_in);

  always #50 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  // Pin level of a compare-role code after n matches, starting from its initial level.
  function automatic logic cmp_level(input logic [3:0] c, input int n);
    logic lvl;
    lvl = c[2];
    for (int k = 0; k < n; k++) begin
      lvl = (c[1:0] == 2'h3) ? !lvl : (c[1:0] == 2'h0) ? lvl : c[1];
    end
    return lvl;
  endfunction

  // Whether a capture-role code takes the counter on a rising or a falling pin edge.
  function automatic logic cap_hit(input logic [3:0] c, input logic rising);
    return rising ? (c[1:0] != 2'h1) : (c[1:0] != 2'h0);
  endfunction

  // Waits n edges, then 1 ns so that the edge's updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    check(16'(reg_rdata), 16'(want));
  endtask

  task automatic pulse(input int g);
    cmp_match[g] <= 1'b1;
    cyc(1);
    cmp_match[g] <= 1'b0;
    cyc(2);
  endtask

  task automatic fn_test(input int g, input logic [3:0] c, input logic sup);
    logic [15:0] cnt;
    logic [1:0]  act;
    logic        on;
    act = c[1:0];
    on = !sup && act != 2'h0;
    cnt = 16'($urandom);
    counter <= cnt;
    wr(4'(g / 2), 8'h00);
    ext_level <= 4'h0;
    cyc(5);
    wr(4'(g / 2), g % 2 ? {c, 1'b0, 3'($urandom)} : {1'b0, 3'($urandom), c});
    cyc(2);
    if (!c[3]) begin
      check(16'(pin_oe[g]), 16'(on));
      if (on) check(16'(pin_out[g]), 16'(cmp_level(c, 0)));
      pulse(g);
      if (on) check(16'(pin_out[g]), 16'(cmp_level(c, 1)));
      pulse(g);
      if (on) check(16'(pin_out[g]), 16'(cmp_level(c, 2)));
    end else begin
      check(16'(pin_oe[g]), 16'h0000);
      ext_level[g] <= 1'b1;
      cyc(3);
      check(16'(cap_strobe[g]), 16'(!sup && cap_hit(c, 1'b1)));
      cyc(3);
      if (!sup && cap_hit(c, 1'b1)) exp_gr[g] = cnt;
      check(gr[g], exp_gr[g]);
      cnt = 16'($urandom);
      counter <= cnt;
      ext_level[g] <= 1'b0;
      cyc(3);
      check(16'(cap_strobe[g]), 16'(!sup && cap_hit(c, 1'b0)));
      cyc(3);
      if (!sup && cap_hit(c, 1'b0)) exp_gr[g] = cnt;
      check(gr[g], exp_gr[g]);
    end
  endtask

  initial begin
    logic [7:0] d;
    void'($urandom(32'h5ac87f4d));
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    for (int a = 0; a < 4; a++) rd(4'(a), 8'h00);
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      wr(4'(i % 3), d);
      rd(4'(i % 3), (i % 3 < 2) ? d : 8'h00);
    end
    $display("test registers done");
    for (int b = 0; b < 4; b++) begin
      bmode <= 2'(b);
      for (int g = 0; g < 4; g++)
        for (int c = 0; c < 16; c++) fn_test(g, 4'(c), (g == 2 && b[0]) || (g == 3 && b[1]));
    end
    $display("test functions done");
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    exp_gr = '{default: 16'h0000};
    check(16'({pin_out, pin_oe, cap_strobe}), 16'h0000);
    for (int a = 0; a < 2; a++) rd(4'(a), 8'h00);
    for (int g = 0; g < 4; g++) check(gr[g], exp_gr[g]);
    $display("test reset done");
    conclude();
  end
endmodule

bind c3io_top c3io_top_asserts chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .counter, .cmp_match, .buffer_mode_a, .buffer_mode_b,
  .chan3_pin_b_in, .pin_out, .pin_oe, .cap_strobe, .chan3_general_a);
